// ---- hw/sesi_top.sv ----
/*
 * Serial EEPROM slave: serial front end on the link clock, status, protection,
 * array and identification page with the self-timed write cycle on the system clock.
 * Assumes nrst is the power-on reset and the master obeys select and hold timing.
 */
// Behaviour
// - Serial link works in clock mode 0 and in mode 3.
// - Storage is 32768 bytes grouped into 64-byte pages.
// - Single bytes, partial pages and full pages of 64 bytes are written.
// - Programming runs internally, self-timed, at most 5 ms.
// - Block protection covers a quarter, a half or the whole array.
// - An extra 64-byte identification page is writable until locked; reset clears the lock.
// - Below power-on threshold instructions are ignored; afterwards reset into standby.
// - First byte after select falls is the opcode; only valid ones decoded.
// - All opcode, address and data bits travel most significant first.
// - Select rising ends the operation or starts the internal write.
// - After select rises, standby follows once any write cycle ends.
// - In standby the serial output is high impedance.
// - Input sampled on rising clock, output changed on falling clock.
// - Protect pin low with arm bit set freezes block and arm bits.
// - Hold suspends the sequence, ignoring clock and data input; release resumes it.
// - Hold tied high means the device never suspends.
// - Decode set/clear latch, status read/write, array read/write opcodes.
// - During a write cycle only the status read is accepted.
// - Write latch clears at power-up and blocks all modifications while clear.
`timescale 1ns/1ps
`default_nettype none

module sesi_top
    import sesi_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES
) (
    // System clock and control
    input  wire logic   clock,
    input  wire logic   nrst,
    input  wire logic   clk_en,
    // Serial link pins
    input  wire logic   sck,
    input  wire logic   cs_n,
    input  wire logic   si,
    input  wire logic   hold_n,
    input  wire logic   wp_n,
    output logic        so,
    output logic        so_oe,
    // Device state for the system
    output logic        busy,
    output sesi_status_t status_out
);

    // Link-side state.
    logic [4:0]        cnt_reg;
    logic [15:0]       sh_reg;
    logic [ADDR_W-1:0] byte_idx_reg;
    sesi_frame_t       frame_reg;
    logic [PAGE_BYTES-1:0] page_mask_reg;
    logic [7:0]        page_buf [PAGE_BYTES];
    logic [7:0]        tx_reg;
    logic              so_reg;
    logic              so_oe_reg;
    sesi_status_t      stat_sck;

    // System-side state.
    logic [7:0]        mem [MEM_BYTES];
    logic [7:0]        id_page [PAGE_BYTES];
    logic              cs_s;
    logic              wp_s;
    logic              cs_prev_reg;
    logic              wel_reg;
    logic [1:0]        bp_reg;
    logic              hw_protect_arm_reg;
    logic              id_lock_reg;
    sesi_wstate_t      state_reg;
    logic [WCNT_W-1:0] wcnt_reg;
    logic [PAGE_W-1:0] cidx_reg;
    logic [ADDR_W-1:0] cmt_addr_reg;
    logic [PAGE_BYTES-1:0] cmt_mask_reg;
    logic              cmt_id_reg;
    logic              busy_reg;
    sesi_status_t      status_reg;

    // Masked opcode compare for the standard set.
    function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
        op_is = ((op & OP_MASK) == code);
    endfunction

    // Protection lookup from the two block bits.
    function automatic logic prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        case (bp)
            BP_QUARTER: prot = (a >= ADDR_QUARTER);
            BP_HALF:    prot = (a >= ADDR_HALF);
            BP_ALL:     prot = 1'b1;
            default:    prot = 1'b0;
        endcase
    endfunction

    // Crossings: select and protect pin into the system clock; status into the link clock.
    sesi_sync #(.W(2), .INIT(2'h3)) u_sync_sys (
        .clk   (clock),
        .rst_n (nrst),
        .en    (clk_en),
        .d     ({cs_n, wp_n}),
        .q     ({cs_s, wp_s})
    );

    // The link clock only runs inside frames, so status may be two edges stale at frame start.
    sesi_sync #(.W(8), .INIT(STATUS_RST)) u_sync_link (
        .clk   (sck),
        .rst_n (1'b1),
        .en    (1'b1),
        .d     (status_reg),
        .q     (stat_sck)
    );

    // Link-side decode helpers.
    logic              is_wr_data;
    logic              rd_stat;
    logic              rd_arr;
    logic              rd_id;
    logic [PAGE_W-1:0] pidx;
    logic [ADDR_W-1:0] rd_ptr;
    logic [7:0]        tx_src;
    logic              oe_clr;

    always_comb begin
        is_wr_data = op_is(frame_reg.opcode, OP_WR_ARRAY) || (frame_reg.opcode == OP_WR_ID);
        rd_id      = (frame_reg.opcode == OP_RD_ID);
        rd_stat    = frame_reg.op_seen && op_is(frame_reg.opcode, OP_RD_STAT)
                     && (cnt_reg >= BIT_OP_DONE);
        rd_arr     = frame_reg.op_seen && (op_is(frame_reg.opcode, OP_RD_ARRAY) || rd_id)
                     && (cnt_reg >= BIT_DATA0) && !stat_sck.busy;
        pidx       = frame_reg.addr[PAGE_W-1:0] + byte_idx_reg[PAGE_W-1:0];
        rd_ptr     = frame_reg.addr[ADDR_W-1:0] + byte_idx_reg;
        if (rd_stat)
            tx_src = stat_sck;
        else if (rd_id)
            tx_src = id_page[pidx];
        else
            tx_src = mem[rd_ptr];
        oe_clr     = cs_n;
    end

    // select frames
    // The bit counter restarts whenever select is high, so every frame begins at bit zero.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt_reg      <= '0;
            byte_idx_reg <= '0;
        end else if (hold_n) begin
            // hold stable
            // Hold is sampled on the edge itself; it only moves while the clock is low.
            cnt_reg <= (cnt_reg == BIT_WRAP) ? BIT_DATA0 : cnt_reg + 5'h01;
            if (cnt_reg[2:0] == 3'h7 && cnt_reg >= BIT_DATA0)
                byte_idx_reg <= byte_idx_reg + 15'h0001;
        end
    end

    // rising edge sampling
    // Frame capture holds after select rises so the system side can read it at leisure.
    always_ff @(posedge sck) begin
        if (!cs_n && hold_n) begin
            sh_reg <= {sh_reg[14:0], si};
            frame_reg.aligned <= (cnt_reg[2:0] == 3'h7);
            if (cnt_reg == 5'h00) begin
                frame_reg.op_seen   <= 1'b0;
                frame_reg.stat_seen <= 1'b0;
                page_mask_reg       <= '0;
            end
            if (cnt_reg == BIT_OP_LAST) begin
                frame_reg.opcode  <= {sh_reg[6:0], si};
                frame_reg.op_seen <= 1'b1;
            end
            if (cnt_reg == BIT_STAT_LAST) begin
                frame_reg.stat_data <= {sh_reg[6:0], si};
                frame_reg.stat_seen <= 1'b1;
            end
            if (cnt_reg == BIT_ADDR_LAST)
                frame_reg.addr <= {sh_reg[14:0], si};
            // page buffer fill
            // Bytes past the page end wrap and overwrite earlier ones in the same page.
            if (cnt_reg[2:0] == 3'h7 && cnt_reg >= BIT_DATA0 && is_wr_data && !stat_sck.busy) begin
                page_buf[pidx]      <= {sh_reg[6:0], si};
                page_mask_reg[pidx] <= 1'b1;
            end
        end
    end

    // modes 0 and 3
    // Data moves on falling edges only; in mode 3 the leading falling edge finds cnt at zero.
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_reg <= 1'b0;
            tx_reg <= '0;
        end else if (hold_n && (rd_stat || rd_arr)) begin
            if (cnt_reg[2:0] == 3'h0) begin
                so_reg <= tx_src[7];
                tx_reg <= {tx_src[6:0], 1'b0};
            end else begin
                so_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // drive only read data
    // Select high clears the enable at once; hold only masks it, so release resumes driving.
    always_ff @(negedge sck or posedge oe_clr) begin
        if (oe_clr) begin
            so_oe_reg <= 1'b0;
        end else if (hold_n) begin
            so_oe_reg <= rd_stat || rd_arr;
        end
    end

    // hold releases the line
    // A gate, not a flop: the held bit must be back on the line before the next rising edge.
    assign so    = so_reg;
    assign so_oe = so_oe_reg && hold_n;

    // System-side command acceptance.
    logic cs_rise;
    logic take;
    logic hw_lock;
    logic stat_ok;
    logic arr_ok;
    logic id_ok;
    logic lock_ok;
    logic cycle_last;
    logic mem_we;
    logic [ADDR_W-1:0] cmt_waddr;

    always_comb begin
        cs_rise    = cs_s && !cs_prev_reg;
        take       = cs_rise && frame_reg.op_seen && frame_reg.aligned && (state_reg == ST_IDLE);
        hw_lock    = hw_protect_arm_reg && !wp_s;
        stat_ok    = take && op_is(frame_reg.opcode, OP_WR_STAT) && frame_reg.stat_seen
                     && wel_reg && !hw_lock;
        arr_ok     = take && op_is(frame_reg.opcode, OP_WR_ARRAY) && wel_reg && (|page_mask_reg);
        id_ok      = take && (frame_reg.opcode == OP_WR_ID) && wel_reg && !id_lock_reg
                     && !frame_reg.addr[ID_LOCK_BIT] && (|page_mask_reg);
        lock_ok    = take && (frame_reg.opcode == OP_WR_ID) && wel_reg && !id_lock_reg
                     && frame_reg.addr[ID_LOCK_BIT];
        cycle_last = (state_reg == ST_WAIT) && (wcnt_reg == WCNT_W'(WRITE_CYC - 1));
        cmt_waddr  = {cmt_addr_reg[ADDR_W-1:PAGE_W], cidx_reg};
        mem_we     = (state_reg == ST_COMMIT) && cmt_mask_reg[cidx_reg] && !cmt_id_reg
                     && !prot(cmt_waddr, bp_reg);
    end

    // power-on standby
    // Select history resets high so a release of reset is never seen as a frame end.
    always_ff @(posedge clock) begin
        if (!nrst)
            cs_prev_reg <= 1'b1;
        else if (clk_en)
            cs_prev_reg <= cs_s;
    end

    // latch opcodes
    // Only valid opcodes act; anything else falls through and leaves the state alone.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wel_reg <= 1'b0;
        end else if (clk_en) begin
            if (take && op_is(frame_reg.opcode, OP_SET_WL))
                wel_reg <= 1'b1;
            else if (take && op_is(frame_reg.opcode, OP_CLR_WL))
                wel_reg <= 1'b0;
            else if (clk_en && cycle_last)
                wel_reg <= 1'b0;
        end
    end

    // frozen protect bits
    // Block and arm bits reset to zero, matching unprogrammed nonvolatile bits.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bp_reg   <= '0;
            hw_protect_arm_reg <= 1'b0;
        end else if (clk_en && stat_ok) begin
            bp_reg   <= {frame_reg.stat_data[3], frame_reg.stat_data[2]};
            hw_protect_arm_reg <= frame_reg.stat_data[7];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst)
            id_lock_reg <= 1'b0;
        else if (clk_en && lock_ok)
            id_lock_reg <= 1'b1;
    end

    // Snapshot of the frame, so a new frame during the commit cannot disturb it.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmt_addr_reg <= '0;
            cmt_mask_reg <= '0;
            cmt_id_reg   <= 1'b0;
        end else if (clk_en && take) begin
            cmt_addr_reg <= frame_reg.addr[ADDR_W-1:0];
            cmt_mask_reg <= page_mask_reg;
            cmt_id_reg   <= (frame_reg.opcode == OP_WR_ID);
        end
    end

    // self-timed cycle
    // The commit walk of 64 slots is counted inside the write time, so WRITE_CYC must exceed 64.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            wcnt_reg  <= '0;
            cidx_reg  <= '0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    wcnt_reg <= '0;
                    cidx_reg <= '0;
                    if (arr_ok || id_ok)
                        state_reg <= ST_COMMIT;
                    else if (stat_ok || lock_ok)
                        state_reg <= ST_WAIT;
                end
                ST_COMMIT: begin
                    wcnt_reg <= wcnt_reg + 18'h00001;
                    cidx_reg <= cidx_reg + 6'h01;
                    if (cidx_reg == PAGE_LAST)
                        state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    wcnt_reg <= wcnt_reg + 18'h00001;
                    if (cycle_last)
                        state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // array storage
    // Contents are nonvolatile and so take no reset.
    always_ff @(posedge clock) begin
        if (clk_en && (state_reg == ST_COMMIT) && cmt_mask_reg[cidx_reg]) begin
            if (cmt_id_reg)
                id_page[cidx_reg] <= page_buf[cidx_reg];
            else if (mem_we)
                mem[cmt_waddr] <= page_buf[cidx_reg];
        end
    end

    // Status byte reads all ones while the internal cycle runs.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            status_reg <= STATUS_RST;
            busy_reg   <= 1'b0;
        end else if (clk_en) begin
            busy_reg <= (state_reg != ST_IDLE);
            if (state_reg != ST_IDLE)
                status_reg <= STATUS_BUSY;
            else
                status_reg <= {hw_protect_arm_reg, 3'h0, bp_reg, wel_reg, 1'b0};
        end
    end

    assign busy       = busy_reg;
    assign status_out = status_reg;

    // Checks on the system clock.
    sequence s_cycle_end;
        clk_en && cycle_last;
    endsequence

    sequence s_busy_frame;
        clk_en && cs_rise && (state_reg != ST_IDLE) && !cycle_last;
    endsequence

    a_wel_powerup: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> !wel_reg) else $error("write latch set after reset");

    a_write_time: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg != ST_IDLE) |-> (wcnt_reg < WCNT_W'(WRITE_CYC)))
        else $error("write cycle overran its time");

    a_cycle_end: assert property (@(posedge clock) disable iff (!nrst)
        s_cycle_end |=> (state_reg == ST_IDLE) && !wel_reg)
        else $error("standby not entered at end of write cycle");

    // The status flop follows the state one enabled clock later.
    a_status_ready: assert property (@(posedge clock) disable iff (!nrst)
        s_cycle_end ##1 clk_en |=> !status_reg.busy)
        else $error("status still busy after write cycle");

    a_busy_ignore: assert property (@(posedge clock) disable iff (!nrst)
        s_busy_frame |=> $stable(wel_reg) && $stable(bp_reg) && $stable(id_lock_reg))
        else $error("command acted during write cycle");

    a_hw_lock: assert property (@(posedge clock) disable iff (!nrst)
        hw_lock |=> $stable(bp_reg) && $stable(hw_protect_arm_reg))
        else $error("protect bits changed under hardware protection");

    a_latch_block: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && cs_rise && !wel_reg && state_reg == ST_IDLE) |=> (state_reg == ST_IDLE))
        else $error("write started with latch clear");

    a_protect_all: assert property (@(posedge clock) disable iff (!nrst)
        (bp_reg == BP_ALL) |-> !mem_we) else $error("protected array written");

    a_id_sticky: assert property (@(posedge clock) disable iff (!nrst)
        id_lock_reg |=> id_lock_reg ##1 id_lock_reg) else $error("page lock cleared");

    a_so_standby: assert property (@(posedge clock) disable iff (!nrst)
        cs_s && $past(cs_s) |-> !so_oe_reg) else $error("output driven in standby");

    // Checks on the link clock.
    a_opcode_take: assert property (@(posedge sck) disable iff (cs_n)
        (hold_n && cnt_reg == BIT_OP_LAST) |=> frame_reg.op_seen
        && (frame_reg.opcode == sh_reg[7:0])) else $error("opcode not captured MSB first");

    a_hold_freeze: assert property (@(posedge sck) disable iff (cs_n)
        !hold_n |=> $stable(cnt_reg) && $stable(sh_reg)) else $error("sequence moved during hold");

endmodule

`default_nettype wire

// ---- hw/sesi_pkg.sv ----
/*
 * Shared constants and carrier types for the serial EEPROM slave front end.
 * Assumes a 50 MHz system clock and a serial master using clock modes 0 or 3.
 */
package sesi_pkg;

    // Array organisation.
    localparam int MEM_BYTES  = 32768;
    localparam int ADDR_W     = 15;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_W     = 6;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 6'h3f;

    // Opcodes; bit 3 is a don't-care in the standard set.
    localparam logic [7:0] OP_MASK     = 8'hf7;
    localparam logic [7:0] OP_SET_WL   = 8'h06;
    localparam logic [7:0] OP_CLR_WL   = 8'h04;
    localparam logic [7:0] OP_RD_STAT  = 8'h05;
    localparam logic [7:0] OP_WR_STAT  = 8'h01;
    localparam logic [7:0] OP_RD_ARRAY = 8'h03;
    localparam logic [7:0] OP_WR_ARRAY = 8'h02;
    localparam logic [7:0] OP_RD_ID    = 8'h83;
    localparam logic [7:0] OP_WR_ID    = 8'h82;
    localparam int         ID_LOCK_BIT = 10;

    // Serial bit counter landmarks (bits received so far).
    localparam logic [4:0] BIT_OP_LAST   = 5'h07;
    localparam logic [4:0] BIT_STAT_LAST = 5'h0f;
    localparam logic [4:0] BIT_ADDR_LAST = 5'h17;
    localparam logic [4:0] BIT_OP_DONE   = 5'h08;
    localparam logic [4:0] BIT_DATA0     = 5'h18;
    localparam logic [4:0] BIT_WRAP      = 5'h1f;

    // Block protection boundaries.
    localparam logic [1:0]        BP_QUARTER   = 2'h1;
    localparam logic [1:0]        BP_HALF      = 2'h2;
    localparam logic [1:0]        BP_ALL       = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_QUARTER = 15'h6000;
    localparam logic [ADDR_W-1:0] ADDR_HALF    = 15'h4000;

    // Self-timed write cycle: longest time, rounded down to whole cycles.
    localparam int T_WRITE_NS    = 5000000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;
    localparam int WCNT_W        = 18;

    // Status byte as seen on the serial line.
    typedef struct packed {
        logic       hw_protect_arm;
        logic [2:0] spare;
        logic       block_protect_hi;
        logic       block_protect_lo;
        logic       write_latch;
        logic       busy;
    } sesi_status_t;

    localparam sesi_status_t STATUS_BUSY = 8'hff;
    localparam sesi_status_t STATUS_RST  = 8'h00;

    // Everything a frame leaves behind for the system side.
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] addr;
        logic [7:0]  stat_data;
        logic        op_seen;
        logic        stat_seen;
        logic        aligned;
    } sesi_frame_t;

    typedef enum {ST_IDLE, ST_COMMIT, ST_WAIT} sesi_wstate_t;

endpackage

// ---- hw/sesi_sync.sv ----
/*
 * Two-flop level synchroniser with clock enable and synchronous reset.
 * Assumes its input is a level that stays put for several destination edges.
 */
`timescale 1ns/1ps
`default_nettype none

module sesi_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Destination clock
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    // Level in and synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // The first stage feeds only the second stage, never any logic.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else if (en) begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule

`default_nettype wire

// ---- tb/sesi_master.sv ----
/*
 * Serial bus master model for the EEPROM slave, clock mode 0 or mode 3.
 * Assumes the slave samples si on rising sck and shifts so on falling sck.
 */
`timescale 1ns/1ps
`default_nettype none

module sesi_master (
    // Serial lines toward the device
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    // Serial lines from the device
    input  wire logic so,
    input  wire logic so_oe
);
    logic cpol;
    logic hold_oe;
    wire logic so_line;

    // A released line shows the inverse of its last bit, so an undriven sample is caught.
    assign so_line = so_oe ? so : ~so;

    // Idle bus; the bench sets cpol to pick the clock mode.
    initial begin
        cpol = 1'b0;
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        hold_oe = 1'b0;
        // A select pulse clears the link-side counters and output flops, which have no other reset.
        #1 cs_n = 1'b1;
    end

    // select framed transfer.
    // The clock stands still between frames, at its idle level.
    task automatic frame(input logic [47:0] tx, input int nb, input int nrx,
                         input int hold_at, output logic [15:0] rx);
        rx = 16'h0000;
        // Park the clock at its idle level before select falls, so mode 3 starts high.
        sck = cpol;
        #32 cs_n = 1'b0;
        #40;
        for (int i = 0; i < 8 * nb + nrx; i++) begin
            sck = 1'b0;
            if (i == hold_at) begin
                #8 hold_n = 1'b0;
                repeat (2) begin
                    #32 sck = 1'b1;
                    si = ~si;
                    #32 sck = 1'b0;
                end
                hold_oe = so_oe;
                #8 hold_n = 1'b1;
            end
            si = (i < 8 * nb) ? tx[8 * nb - 1 - i] : ~si;
            #32 sck = 1'b1;
            rx = (i >= 8 * nb) ? {rx[14:0], so_line} : rx;
            #32;
        end
        sck = cpol;
        #32 cs_n = 1'b1;
        si = ~si;  // A released line must not look like stale data.
        #300;
    endtask
endmodule
`default_nettype wire

// ---- tb/spi_eeprom_slave_interface_test.sv ----
/*
 * Self-checking bench for the serial EEPROM slave front end.
 * Assumes sesi_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_slave_interface_test import sesi_pkg::*;;
    logic         clock, nrst, clk_en, wp_n, busy;
    logic         sck, cs_n, si, hold_n, so, so_oe;
    sesi_status_t status_out;
    logic [15:0]  rx;
    int           mismatches = 0;
    int           num_checks = 0;
    int           cycles = 0;

    // Short write cycle keeps the run brief; it still exceeds one page.
    sesi_top #(.WRITE_CYC(200)) dut (.clock(clock), .nrst(nrst), .clk_en(clk_en),
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
        .so_oe(so_oe), .busy(busy), .status_out(status_out));
    sesi_master m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));

    // System clock at 50 MHz.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard well above the expected run length.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic fr(input logic [47:0] tx, input int nb, input int nrx, input int h = -1);
        m.frame(tx, nb, nrx, h, rx);
        check(16'(so_oe), 16'h0000);
    endtask

    // Poll the status byte until the busy bit clears, with a bound.
    task automatic wait_idle();
        int n = 0;
        do begin
            fr(48'h05, 1, 8);
            n++;
        end while (rx[0] !== 1'b0 && n < 40);
        check(16'(n < 40), 16'h0001);
    endtask

    task automatic wr(input logic [47:0] tx, input int nb);
        fr(48'h06, 1, 0);
        fr(tx, nb, 0);
        wait_idle();
    endtask

    // Main sequence.
    initial begin
        clk_en = 1'b1;
        nrst = 1'b0;
        wp_n = 1'b1;
        repeat (16) @(posedge clock);
        #1 nrst = 1'b1;
        check(16'(busy), 16'h0000);
        check(16'(status_out), 16'h0000);
        repeat (4) @(posedge clock);
        fr(48'h05, 1, 8);
        check(rx, 16'h0000);
        fr(48'h02000055, 4, 0);
        check(16'(busy), 16'h0000);
        $display("test reset done");
        fr(48'h06, 1, 0);
        fr(48'h05, 1, 8);
        check(rx, 16'h0002);
        check(16'(status_out), 16'h0002);
        fr(48'h04, 1, 0);
        fr(48'h05, 1, 8);
        check(rx, 16'h0000);
        $display("test latch done");
        fr(48'h06, 1, 0);
        fr(48'h02003ea1a2a3, 6, 0);
        check(16'(busy), 16'h0001);
        check(16'(status_out), 16'h00ff);
        fr(48'h06, 1, 0);
        fr(48'h05, 1, 8);
        check(rx, 16'h00ff);
        wait_idle();
        check(16'(status_out), 16'h0000);
        fr(48'h03003e, 3, 16, 28);
        check(rx, 16'ha1a2);
        check(16'(m.hold_oe), 16'h0000);
        fr(48'h030000, 3, 8);
        check(rx, 16'h00a3);
        $display("test page write done");
        m.cpol = 1'b1;
        fr(48'h03003f, 3, 8);
        check(rx, 16'h00a2);
        m.cpol = 1'b0;
        $display("test mode three done");
        wr(48'h018c, 2);
        fr(48'h05, 1, 8);
        check(rx, 16'h008c);
        @(posedge clock);
        #1 wp_n = 1'b0;
        repeat (4) @(posedge clock);
        wr(48'h0100, 2);
        fr(48'h05, 1, 8);
        check(rx, 16'h008e);
        fr(48'h02000055, 4, 0);
        wait_idle();
        fr(48'h030000, 3, 8);
        check(rx, 16'h00a3);
        @(posedge clock);
        #1 wp_n = 1'b1;
        repeat (4) @(posedge clock);
        wr(48'h0100, 2);
        fr(48'h05, 1, 8);
        check(rx, 16'h0000);
        // quarter boundary, one byte each side.
        wr(48'h02600011, 4);
        wr(48'h0104, 2);
        wr(48'h02600077, 4);
        wr(48'h025fff66, 4);
        fr(48'h035fff, 3, 16);
        check(rx, 16'h6611);
        $display("test protection done");
        wr(48'h8200003c, 4);
        wr(48'h820400, 3);
        wr(48'h820000c3, 4);
        fr(48'h830000, 3, 8);
        check(rx, 16'h003c);
        $display("test id page done");
        print_verdict();
    end
endmodule
`default_nettype wire
